// [design/ntsp_pkg.sv]
// constants, carriers and state layout for the network serial tunnel port
// assumes a 40 MHz system clock and an APB master with 32-bit data
package ntsp_pkg;
    // ==========================================================
    // timing
    localparam int CLK_HZ        = 40_000_000;
    localparam int OVS           = 16;
    localparam int FLASH_MS      = 250;
    localparam int FLASH_CYC_DEF = CLK_HZ / 1000 * FLASH_MS;
    localparam int B1200  = 1200;
    localparam int B2400  = 2400;
    localparam int B4800  = 4800;
    localparam int B7200  = 7200;
    localparam int B9600  = 9600;
    localparam int B14400 = 14400;
    localparam int B19200 = 19200;
    localparam int B28800 = 28800;
    localparam int B38400 = 38400;
    localparam int B57600 = 57600;
    localparam int B31250 = 31250;
    // ==========================================================
    // slots and register map
    localparam int         NSLOT    = 14;
    localparam logic [3:0] SLOT_MAX = 4'hD;
    localparam logic [11:0] A_CFG   = 12'h000;
    localparam logic [11:0] A_ASSIGN = 12'h004;
    localparam logic [11:0] A_CMD   = 12'h008;
    localparam logic [11:0] A_STAT  = 12'h00C;
    localparam logic [11:0] A_INUSE = 12'h010;
    localparam logic [11:0] A_TXD   = 12'h014;
    localparam logic [11:0] A_RXD   = 12'h018;
    localparam logic [11:0] A_ITY   = 12'h01C;
    localparam logic [11:0] A_OTY   = 12'h020;
    // ==========================================================
    // types
    typedef enum logic [1:0] {
        TY_NONE = 2'h0,
        TY_SER  = 2'h1,
        TY_MIDI = 2'h2,
        TY_GPIO = 2'h3
    } ntsp_type_t;
    typedef enum logic [2:0] {
        U_IDLE  = 3'h0,
        U_START = 3'h1,
        U_DATA  = 3'h2,
        U_PAR   = 3'h3,
        U_STOP  = 3'h4
    } ntsp_ust_t;
    typedef struct packed {
        logic [NSLOT-1:0]      inuse;
        logic [NSLOT-1:0][3:0] data;
    } ntsp_net_t;
    typedef struct packed {
        logic                   cfg_ok;
        logic [9:0]             sw;
        logic                   ctrl;
        logic [11:0]            bd;
        logic [31:0]            rdata;
        logic                   err;
        logic                   pend;
        logic [3:0]             ps;
        ntsp_type_t             pt;
        logic                   po;
        logic                   deny;
        ntsp_type_t [NSLOT-1:0] ity;
        ntsp_type_t [NSLOT-1:0] oty;
        logic [23:0]            fl_cnt;
        logic                   fl;
        ntsp_ust_t              ts;
        logic [3:0]             tt;
        logic [2:0]             tb;
        logic [7:0]             tsh;
        logic                   tp;
        logic                   tsb;
        logic                   txd;
        ntsp_ust_t              rs;
        logic [3:0]             rt;
        logic [2:0]             rb;
        logic [7:0]             rsh;
        logic                   rp;
        logic                   rsb;
        logic                   rfb;
        logic [7:0]             rdat;
        logic                   rv;
        logic                   rpe;
        logic                   rfe;
        logic                   midi_o;
        logic [3:0]             gpio_o;
        logic [NSLOT-1:0]       inuse_led;
        logic [2:0]             tled;
        logic                   cled;
        ntsp_net_t              net;
    } ntsp_state_t;
    // ==========================================================
    // helpers
    function automatic logic [11:0] ntsp_div(input logic [3:0] c);
        int b;
        b = B9600;
        case (c)
            4'h0: b = B1200;
            4'h1: b = B2400;
            4'h2: b = B4800;
            4'h3: b = B7200;
            4'h4: b = B9600;
            4'h5: b = B14400;
            4'h6: b = B19200;
            4'h7: b = B28800;
            4'h8: b = B38400;
            4'h9: b = B57600;
            4'hA: b = B31250;
            default: b = B9600;
        endcase
        return 12'(CLK_HZ / (OVS * b));
    endfunction
    function automatic ntsp_state_t ntsp_rst();
        ntsp_state_t s;
        s          = '0;
        s.txd      = 1'b1;
        s.midi_o   = 1'b1;
        s.net.data = {NSLOT{4'hF}};
        return s;
    endfunction
    localparam ntsp_state_t ST_RST = ntsp_rst();
endpackage

// [design/ntsp_top.sv]
// network serial tunnel port: switch-configured uart, slot assignment,
// slot lanes for serial, midi and contact data, apb register slave
// assumes all pins synchronous to CLK and one network controller
// Operation
// - switches one to four give baud code
// - codes 0 to 7 select 1200..28800
// - codes 8,9,A select 38400, 57600, 31250
// - switch five selects seven or eight bits
// - switches six, seven set parity use, sense
// - switch eight selects one or two stops
// - switches nine, ten not used for framing
// - switch ten at power-up makes controller
// - fourteen slots whatever the network mode
// - slots independent of audio settings
// - grant only when all needed slots free
// - broadcast assigned inputs, show in-use
// - serial session takes two adjacent slots
// - midi bytes pass through unchanged
// - one midi input slot, many outputs
// - midi in and out work independently
// - four contact ins, outs, per-input mode
// - flash pending, confirm commits, cancel drops
// - confirm with no type deactivates slot
// - outputs reproduce same-numbered slot data
`timescale 1ns/1ps
module ntsp_top
    import ntsp_pkg::*;
#(
    parameter int FLASH_CYC = FLASH_CYC_DEF
) (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic [9:0]  DIP_SW,
    input  wire logic [3:0]  GPIO_MODE,
    input  wire logic [3:0]  GPIO_IN,
    output logic [3:0]       GPIO_OUT,
    input  wire logic        SER_RXD,
    output logic             SER_TXD,
    input  wire logic        MIDI_IN,
    output logic             MIDI_OUT,
    input  wire ntsp_net_t   NET_RX,
    output ntsp_net_t        NET_TX,
    output logic             CTRL_LED,
    output logic [NSLOT-1:0] INUSE_LED,
    output logic [2:0]       TYPE_LED,
    output logic             CONFIRM_LED
);
    ntsp_state_t           q;
    ntsp_state_t           d;
    logic                  tick;
    logic                  setup;
    logic                  acc;
    logic                  wr;
    logic                  cfm;
    logic                  grant;
    logic                  busy;
    logic                  sout;
    logic                  txbit;
    logic [3:0]            code;
    logic [2:0]            last;
    logic [3:0]            s1;
    logic [15:0]           vx;
    logic [3:0]            gacc;
    logic [NSLOT-1:0]      own;
    logic [NSLOT-1:0]      view;
    logic [NSLOT-1:0]      mi_in;
    logic [NSLOT-1:0]      so_v;
    logic [NSLOT-1:0]      so_any;
    logic [NSLOT-1:0]      mo_v;
    logic [NSLOT-1:0][3:0] go_v;
    logic [NSLOT-1:0][3:0] lane_d;
    logic [3:0]            gin;

    // ==========================================================
    // slot lanes
    // per-input mode
    // isolated inputs read a closure as low, so flip them to active high
    assign gin = GPIO_IN ^ GPIO_MODE;

    for (genvar i = 0; i < NSLOT; i++) begin : g_slot
        if (i > 0) begin : g_pair
            assign own[i] = (q.ity[i] != TY_NONE) || (q.ity[i-1] == TY_SER);
        end else begin : g_first
            assign own[i] = (q.ity[i] != TY_NONE);
        end
        assign mi_in[i]  = (q.ity[i] == TY_MIDI);
        assign so_any[i] = (q.oty[i] == TY_SER);
        assign so_v[i] = (q.oty[i] != TY_SER) || NET_RX.data[i][0];
        assign mo_v[i] = (q.oty[i] != TY_MIDI) || NET_RX.data[i][0];
        assign go_v[i] = (q.oty[i] == TY_GPIO) ? NET_RX.data[i] : 4'h0;
        assign lane_d[i] = (q.ity[i] == TY_SER)  ? {3'h7, SER_RXD} :
                           (q.ity[i] == TY_MIDI) ? {3'h7, MIDI_IN} :
                           (q.ity[i] == TY_GPIO) ? gin : 4'hF;
    end

    assign view = NET_RX.inuse | own;
    assign vx   = {2'b00, view};
    assign sout = |so_any;

    // ==========================================================
    // next state
    always_comb begin
        d     = q;
        setup = PSEL && !PENABLE;
        acc   = PSEL && PENABLE;
        wr    = acc && PWRITE;
        code  = {q.sw[0], q.sw[1], q.sw[2], q.sw[3]};
        last  = q.sw[4] ? 3'h7 : 3'h6;
        s1    = q.ps + 4'h1;
        tick  = (q.bd == 12'h000);
        gacc  = 4'h0;
        for (int i = 0; i < NSLOT; i++) begin
            gacc = gacc | go_v[i];
        end

        if (!q.cfg_ok) begin
            d.cfg_ok = 1'b1;
            d.sw     = DIP_SW;
            d.ctrl   = DIP_SW[9];
        end

        // baud tick counter
        // held at zero until the switches are in, so the first reload uses them
        if (!q.cfg_ok) begin
            d.bd = 12'h000;
        end else begin
            d.bd = tick ? ntsp_div(code) - 12'h001 : q.bd - 12'h001;
        end

        // apb read data is latched in setup so the access phase never waits
        if (setup) begin
            d.err   = 1'b0;
            d.rdata = 32'h0000_0000;
            case (PADDR)
                A_CFG:    d.rdata = {22'h00_0000, q.sw};
                A_ASSIGN: d.rdata = {25'h000_0000, q.po, q.pt, q.ps};
                A_STAT:   d.rdata = {29'h0000_0000, q.ctrl, q.deny, q.pend};
                A_INUSE:  d.rdata = {18'h0_0000, view};
                A_TXD:    d.rdata = {23'h00_0000, q.ts != U_IDLE, 8'h00};
                A_RXD:    d.rdata = {21'h00_0000, q.rfe, q.rpe, q.rv, q.rdat};
                A_ITY:    d.rdata = {4'h0, q.ity};
                A_OTY:    d.rdata = {4'h0, q.oty};
                default:  d.err = !PWRITE || (PADDR != A_CMD);
            endcase
            if (PWRITE && PADDR == A_CMD) begin
                d.err = 1'b0;
            end
        end

        if (wr && PADDR == A_ASSIGN && PWDATA[3:0] <= SLOT_MAX) begin
            d.pend = 1'b1;
            d.deny = 1'b0;
            d.ps   = PWDATA[3:0];
            d.pt   = ntsp_type_t'(PWDATA[5:4]);
            d.po   = PWDATA[6];
        end

        busy  = vx[q.ps] || (q.pt == TY_SER && (q.ps == SLOT_MAX || vx[s1]));
        cfm   = wr && PADDR == A_CMD && PWDATA[0] && q.pend;
        grant = cfm && (q.po || q.pt == TY_NONE || !busy);

        if (cfm) begin
            d.pend = 1'b0;
            d.deny = !grant;
            if (q.po) begin
                d.oty[q.ps] = q.pt;
            end else if (grant) begin
                if (q.pt == TY_MIDI) begin
                    for (int i = 0; i < NSLOT; i++) begin
                        if (q.ity[i] == TY_MIDI) begin
                            d.ity[i] = TY_NONE;
                        end
                    end
                end
                d.ity[q.ps] = q.pt;
            end
        end else if (wr && PADDR == A_CMD && PWDATA[1]) begin
            d.pend = 1'b0;
        end

        if (q.pend) begin
            d.fl_cnt = q.fl_cnt + 24'h00_0001;
            if (q.fl_cnt == 24'(FLASH_CYC - 1)) begin
                d.fl_cnt = 24'h00_0000;
                d.fl     = !q.fl;
            end
        end else begin
            d.fl_cnt = 24'h00_0000;
            d.fl     = 1'b1;
        end
        d.cled = d.pend && d.fl;
        d.tled = 3'h0;
        if (d.pend && d.fl && d.pt != TY_NONE) begin
            d.tled[d.pt - 2'h1] = 1'b1;
        end

        if (wr && PADDR == A_TXD && q.ts == U_IDLE) begin
            d.ts  = U_START;
            d.tt  = 4'h0;
            d.tsh = PWDATA[7:0];
            d.tp  = q.sw[6] ^ (q.sw[4] ? ^PWDATA[7:0] : ^PWDATA[6:0]);
        end else if (tick && q.ts != U_IDLE) begin
            d.tt = q.tt + 4'h1;
            if (q.tt == 4'hF) begin
                unique case (q.ts)
                    U_START: begin
                        d.ts = U_DATA;
                        d.tb = 3'h0;
                    end
                    U_DATA: begin
                        d.tsh = q.tsh >> 1;
                        d.tb  = q.tb + 3'h1;
                        d.tsb = 1'b0;
                        if (q.tb == last) begin
                            d.ts = q.sw[5] ? U_PAR : U_STOP;
                        end
                    end
                    U_PAR: begin
                        d.ts = U_STOP;
                    end
                    U_STOP: begin
                        if (q.sw[7] && !q.tsb) begin
                            d.tsb = 1'b1;
                        end else begin
                            d.ts = U_IDLE;
                        end
                    end
                    default: d.ts = U_IDLE;
                endcase
            end
        end
        unique case (d.ts)
            U_START: txbit = 1'b0;
            U_DATA:  txbit = d.tsh[0];
            U_PAR:   txbit = d.tp;
            default: txbit = 1'b1;
        endcase
        // a tunnelled serial slot shares the line; both idle at mark
        d.txd = txbit && (&so_v);

        // receiver; a read of the data word clears valid, a new byte wins
        if (acc && !PWRITE && PADDR == A_RXD) begin
            d.rv = 1'b0;
        end
        if (tick) begin
            d.rt = q.rt + 4'h1;
            unique case (q.rs)
                U_IDLE: begin
                    d.rt = 4'h0;
                    if (!SER_RXD) begin
                        d.rs = U_START;
                    end
                end
                U_START: begin
                    if (q.rt == 4'h7) begin
                        d.rt  = 4'h0;
                        d.rb  = 3'h0;
                        d.rsh = 8'h00;
                        d.rp  = 1'b0;
                        // a short low glitch is not a start bit
                        d.rs  = SER_RXD ? U_IDLE : U_DATA;
                    end
                end
                U_DATA: begin
                    if (q.rt == 4'hF) begin
                        d.rsh = {SER_RXD, q.rsh[7:1]};
                        d.rb  = q.rb + 3'h1;
                        d.rsb = 1'b0;
                        d.rfb = 1'b0;
                        if (q.rb == last) begin
                            d.rs = q.sw[5] ? U_PAR : U_STOP;
                        end
                    end
                end
                U_PAR: begin
                    if (q.rt == 4'hF) begin
                        d.rp = SER_RXD ^ q.sw[6] ^ (^q.rsh);
                        d.rs = U_STOP;
                    end
                end
                U_STOP: begin
                    if (q.rt == 4'hF) begin
                        d.rfb = q.rfb || !SER_RXD;
                        if (q.sw[7] && !q.rsb) begin
                            d.rsb = 1'b1;
                        end else begin
                            d.rs   = U_IDLE;
                            d.rv   = 1'b1;
                            d.rpe  = q.rp;
                            d.rfe  = q.rfb || !SER_RXD;
                            d.rdat = q.sw[4] ? q.rsh : {1'b0, q.rsh[7:1]};
                        end
                    end
                end
                default: d.rs = U_IDLE;
            endcase
        end

        d.midi_o    = &mo_v;
        d.gpio_o    = gacc;
        d.net.data  = lane_d;
        d.net.inuse = q.ctrl ? (own | NET_RX.inuse) : own;
        d.inuse_led = view;
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // outputs
    assign PRDATA      = q.rdata;
    assign PREADY      = 1'b1;
    assign PSLVERR     = PSEL && PENABLE && q.err;
    assign SER_TXD     = q.txd;
    assign MIDI_OUT    = q.midi_o;
    assign GPIO_OUT    = q.gpio_o;
    assign NET_TX      = q.net;
    assign CTRL_LED    = q.ctrl;
    assign INUSE_LED   = q.inuse_led;
    assign TYPE_LED    = q.tled;
    assign CONFIRM_LED = q.cled;

    // ==========================================================
    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    cfg_hold_a: assert property (q.cfg_ok |=> $stable(q.sw))
        else $error("switch copy changed after capture");
    ctrl_led_a: assert property (q.cfg_ok |-> CTRL_LED == q.sw[9])
        else $error("controller indicator disagrees with switch ten");
    baud_tick_a: assert property (q.cfg_ok && tick |=> q.bd == ntsp_div(code) - 12'h001)
        else $error("baud tick reload wrong");
    txd_idle_a: assert property (q.ts == U_IDLE && !$past(sout) |-> SER_TXD)
        else $error("transmit line not at mark while idle");
    deny_a: assert property (cfm && !q.po && q.pt != TY_NONE && busy |=> q.deny && !q.pend)
        else $error("busy slot request was not refused");
    bcast_a: assert property (cfm && grant && !q.po && q.pt != TY_NONE && q.ctrl
        |-> ##2 NET_TX.inuse[$past(q.ps, 2)])
        else $error("granted input slot not broadcast");
    pair_a: assert property (cfm && grant && !q.po && q.pt == TY_SER
        |=> own[q.ps] && own[q.ps + 4'h1])
        else $error("serial session did not claim two slots");
    midi_one_a: assert property ($onehot0(mi_in))
        else $error("more than one midi input slot");
    flash_off_a: assert property (!q.pend |-> !CONFIRM_LED && TYPE_LED == 3'h0)
        else $error("indicators flash with nothing pending");
    deact_a: assert property (cfm && !q.po && q.pt == TY_NONE |=> q.ity[q.ps] == TY_NONE)
        else $error("confirm without type left slot active");
    midi_pass_a: assert property (##1 MIDI_OUT == $past(&mo_v))
        else $error("midi output not a copy of its slot");
endmodule // ntsp_top

// [tb/ntsp_dev.sv]
// uart partner: the external serial device on the tunnel port
// assumes the bench passes the bit length in clock cycles
`timescale 1ns/1ps
module ntsp_dev (
    input  wire logic CLK,
    input  wire logic line_i,
    output logic      line_o
);
    // a released serial line rests at mark
    initial line_o = 1'b1;
    // ==========================================================
    // receive
    // sample at bit centres
    task automatic recv(input int bt, output logic [7:0] d, output logic p,
                        output logic [1:0] s);
        int n;
        n = 0;
        while (line_i !== 1'b0 && n < 30 * bt) begin
            @(posedge CLK);
            n++;
        end
        repeat (bt / 2) @(posedge CLK);
        for (int i = 0; i < 11; i++) begin
            repeat (bt) @(posedge CLK);
            if (i < 8) d[i] = line_i;
            else if (i == 8) p = line_i;
            else s[i - 9] = line_i;
        end
    endtask
    // ==========================================================
    // send
    // odd parity, two stops
    task automatic send(input int bt, input logic [7:0] d, input logic bad);
        logic [11:0] f;
        f = {2'b11, (~^d) ^ bad, d, 1'b0};
        for (int i = 0; i < 12; i++) begin
            line_o <= f[i];
            repeat (bt) @(posedge CLK);
        end
    endtask
endmodule // ntsp_dev

// [tb/testbench.sv]
// self-checking bench: apb tasks, uart partner, slot grant and lane checks
// assumes a zero or short wait apb slave and no other network module
`timescale 1ns/1ps
module testbench
    import ntsp_pkg::*;
();
    localparam int BIT  = (CLK_HZ / (OVS * B57600)) * OVS;
    localparam int BIT2 = (CLK_HZ / (OVS * B31250)) * OVS;
    logic             CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, er, p;
    logic             SER_RXD, SER_TXD, MIDI_IN, MIDI_OUT, CTRL_LED, CONFIRM_LED;
    logic [1:0]       s;
    logic [2:0]       TYPE_LED;
    logic [3:0]       GPIO_MODE, GPIO_IN, GPIO_OUT;
    logic [7:0]       b;
    logic [9:0]       DIP_SW;
    logic [11:0]      PADDR;
    logic [31:0]      PWDATA, PRDATA, rd;
    logic [NSLOT-1:0] INUSE_LED;
    ntsp_net_t        NET_RX, NET_TX;
    int               n_fail, check_count, cyc, h1, h2;
    logic [7:0]       aw [6] = '{8'h1D, 8'h13, 8'h11, 8'h27, 8'h28, 8'h08};
    logic             dn [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    logic [13:0]      ue [6] = '{14'h0010, 14'h0010, 14'h0016, 14'h0096, 14'h0116, 14'h0016};
    logic [7:0]       tx_v [2] = '{8'hA5, 8'h07};

    ntsp_top #(.FLASH_CYC(4)) dut (
        .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .DIP_SW(DIP_SW), .GPIO_MODE(GPIO_MODE), .GPIO_IN(GPIO_IN),
        .GPIO_OUT(GPIO_OUT), .SER_RXD(SER_RXD), .SER_TXD(SER_TXD), .MIDI_IN(MIDI_IN),
        .MIDI_OUT(MIDI_OUT), .NET_RX(NET_RX), .NET_TX(NET_TX), .CTRL_LED(CTRL_LED),
        .INUSE_LED(INUSE_LED), .TYPE_LED(TYPE_LED), .CONFIRM_LED(CONFIRM_LED)
    );
    ntsp_dev dev (.CLK(CLK), .line_i(SER_TXD), .line_o(SER_RXD));

    always #12.5 CLK = ~CLK;
    // ==========================================================
    // checking and closing
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // a stuck handshake or silent line ends here instead of hanging
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 90000) begin
            n_fail++;
            give_verdict();
        end
    end
    // ==========================================================
    // bus cycles
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        @(posedge CLK);
        while (PREADY !== 1'b1) @(posedge CLK);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic slot(input logic [7:0] w, input logic d, input logic [13:0] u);
        apb(1'b1, A_ASSIGN, {24'h0000_00, w});
        apb(1'b0, A_STAT, '0);
        chk("pending", rd[0], 1'b1);
        apb(1'b1, A_CMD, 32'h0000_0001);
        repeat (2) @(posedge CLK);
        apb(1'b0, A_STAT, '0);
        chk("deny", rd[1:0], {d, 1'b0});
        chk("net use", NET_TX.inuse, u);
        chk("use led", INUSE_LED, u);
    endtask
    // ==========================================================
    // main sequence
    initial begin
        {CLK, PSEL, PENABLE, PWRITE, PADDR, PWDATA, GPIO_MODE, GPIO_IN} = '0;
        {n_fail, check_count, cyc} = '0;
        RST = 1'b1;
        MIDI_IN = 1'b1;
        // baud code 9, 8 bits, odd parity, 2 stops, controller
        DIP_SW = 10'h2F9;
        NET_RX.inuse = '0;
        NET_RX.data = {NSLOT{4'hF}};
        repeat (10) @(posedge CLK);
        RST <= 1'b0;
        repeat (3) @(posedge CLK);
        DIP_SW <= '0;
        apb(1'b0, A_CFG, '0);
        chk("cfg", rd, 32'h0000_02F9);
        chk("cfg err", er, 1'b0);
        apb(1'b0, A_STAT, '0);
        chk("ctrl stat", rd[2], 1'b1);
        chk("ctrl led", CTRL_LED, 1'b1);
        apb(1'b0, 12'h0FC, '0);
        chk("unmapped", er, 1'b1);
        foreach (tx_v[i]) begin
            fork
                apb(1'b1, A_TXD, {24'h0000_00, tx_v[i]});
                dev.recv(BIT, b, p, s);
            join
            chk("tx data", b, tx_v[i]);
            chk("tx parity", p, ~^tx_v[i]);
            chk("tx stops", s, 2'b11);
            // the frame still owns the line for half a stop bit; a write now is dropped
            do apb(1'b0, A_TXD, '0); while (rd[8] !== 1'b0);
        end
        dev.send(BIT, 8'h5A, 1'b0);
        apb(1'b0, A_RXD, '0);
        chk("rx", rd[10:0], {3'b001, 8'h5A});
        apb(1'b0, A_RXD, '0);
        chk("rx cleared", rd[8], 1'b0);
        dev.send(BIT, 8'hC3, 1'b1);
        apb(1'b0, A_RXD, '0);
        chk("rx parity", rd[10:0], {3'b011, 8'hC3});
        // slot 4 claimed elsewhere on the network
        NET_RX.inuse <= 14'h0010;
        repeat (3) @(posedge CLK);
        chk("use led", INUSE_LED, 14'h0010);
        foreach (aw[i]) slot(aw[i], dn[i], ue[i]);
        apb(1'b1, A_ASSIGN, 32'h0000_0039);
        {h1, h2} = '0;
        repeat (12) begin
            @(posedge CLK);
            h1 += (CONFIRM_LED === 1'b1);
            h2 += (TYPE_LED[2] === 1'b1);
        end
        chk("flash", {h1 > 0 && h1 < 12, h2 > 0 && h2 < 12}, 2'b11);
        apb(1'b1, A_CMD, 32'h0000_0002);
        apb(1'b0, A_STAT, '0);
        chk("cancel", rd[0], 1'b0);
        chk("cancel use", NET_TX.inuse, 14'h0016);
        slot(8'h68, 1'b0, 14'h0016);
        slot(8'h27, 1'b0, 14'h0096);
        slot(8'h75, 1'b0, 14'h0096);
        slot(8'h3A, 1'b0, 14'h0496);
        NET_RX.data[8] <= 4'h0;
        NET_RX.data[5] <= 4'hA;
        MIDI_IN <= 1'b0;
        GPIO_MODE <= 4'h3;
        GPIO_IN <= 4'h5;
        repeat (4) @(posedge CLK);
        chk("midi out", MIDI_OUT, 1'b0);
        chk("midi lane", NET_TX.data[7][0], 1'b0);
        chk("gpio out", GPIO_OUT, 4'hA);
        chk("gpio lane", NET_TX.data[10], 4'h6);
        // second reset: midi rate code, 7 bits, no parity, 1 stop
        RST <= 1'b1;
        DIP_SW <= 10'h005;
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        repeat (3) @(posedge CLK);
        chk("ctrl off", CTRL_LED, 1'b0);
        fork
            apb(1'b1, A_TXD, 32'h0000_0045);
            dev.recv(BIT2, b, p, s);
        join
        // the eighth slot already carries the stop bit
        chk("tx seven", b, 8'hC5);
        give_verdict();
    end
endmodule // testbench
